// File: rtl/llc_prot_pkg.sv
// Constants, types and bus carriers for the resonant half-bridge protection block.
// Assumes a 250 MHz system clock; all comparator inputs are synchronous to it.
// Contract
// - Five consecutive overvoltage cycles cause fault.
// - Fault lasts one second, then startup.
// - Overvoltage event on positive or negative threshold.
// - Startup uses bias sense for burst programming.
// - Low-side lockout on gate supply, high on bootstrap.
// - Drivers low power during burst off; the code asserts it in run mode only, not during startup.
// - Slew done needs rise then fall.
// - No slew done ends at maximum dead time.
// - Measured dead time reused for other transition.
// - Wrong current polarity at gate fall flags region.
// - Region flag held until next gate fall.
// - Region recovery: flip, slew or timeout turns on.
// - Region handling stretches maximum dead time 150us.
// - Region detection pulls soft-start pin low.
// - Region detection suppressed at light load.
// - Four consecutive peak overcurrent cycles cause fault.
// - Average above high threshold 2 ms faults.
// - Average above low threshold 50 ms faults.
// - Bulk below stop level faults immediately.
// - Polarity edges ignored first 400 ns.
// - Startup ignores peak overcurrent first fifteen cycles.
// - Bootstrap undervoltage disables only high gate.
// - Gate supply undervoltage: both off, fault.
package llc_prot_pkg;

  localparam int CLK_MHZ        = 250;
  localparam int FAULT_WAIT_MS  = 1000;
  localparam int AVG_OVERCURRENT_HIGH_WAIT_MS   = 2;
  localparam int AVG_OVERCURRENT_LOW_WAIT_MS   = 50;
  localparam int ZCS_MAX_DT_US  = 150;
  localparam int MAX_DT_NS      = 1000;
  localparam int BLANK_NS       = 400;
  localparam int FAULT_WAIT_CYC = FAULT_WAIT_MS * CLK_MHZ * 1000;
  localparam int AVG_OVERCURRENT_HIGH_WAIT_CYC  = AVG_OVERCURRENT_HIGH_WAIT_MS * CLK_MHZ * 1000;
  localparam int AVG_OVERCURRENT_LOW_WAIT_CYC  = AVG_OVERCURRENT_LOW_WAIT_MS * CLK_MHZ * 1000;
  localparam int ZCS_MAX_DT_CYC = ZCS_MAX_DT_US * CLK_MHZ;
  localparam int MAX_DT_CYC     = MAX_DT_NS * CLK_MHZ / 1000;
  localparam int BLANK_CYC      = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int OVP_CYCLES     = 5;
  localparam int PEAK_OVERCURRENT_CYCLES    = 4;
  localparam int START_CYCLES   = 15;

  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] DTIME_OFS  = 8'h08;
  localparam int CTRL_EN_BIT        = 0;
  localparam logic CTRL_EN_RST      = 1'b0;
  localparam int ST_MODE_LSB        = 0;
  localparam int ST_ZCS_BIT         = 2;
  localparam int ST_CAUSE_LSB       = 8;

  localparam int C_OVP  = 0;
  localparam int C_PEAK_OVERCURRENT = 1;
  localparam int C_AVG_OVERCURRENT_HIGH = 2;
  localparam int C_AVG_OVERCURRENT_LOW = 3;
  localparam int C_UVP  = 4;
  localparam int C_REGULATED_GATE_SUPPLY = 5;
  localparam int CAUSE_W = 6;

  typedef enum logic [1:0] {MODE_IDLE, MODE_START, MODE_RUN, MODE_FAULT} mode_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic bias_winding_pos;
    logic bias_winding_neg;
    logic peak_overcurrent;
    logic avg_overcurrent_high;
    logic avg_overcurrent_low;
    logic bulk_below_stop;
    logic regulated_gate_supply_uv;
    logic bootstrap_rail_uv;
    logic current_polarity;
    logic switch_node_slewing;
    logic light_load;
    logic burst_off;
  } sense_s;

endpackage

// File: rtl/slew_done_det.sv
// Slew-completion detector for the switch node during a dead time.
// Assumes the slewing comparator is synchronous and arm is a clean level.
`timescale 1ns/1ps
module slew_done_det (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic arm_i,
  input  wire logic slewing_i,
  output logic      done_o
);
  typedef struct packed {
    logic seen;
  } det_s;

  det_s s_r;
  det_s s_nxt;

  // A slow edge that never crosses the threshold yields no done; any rise then fall, noise included, gives one
  always_comb begin
    s_nxt = s_r;
    if (!arm_i) begin
      s_nxt.seen = 1'b0;
    end else if (slewing_i) begin
      s_nxt.seen = 1'b1;
    end
  end

  assign done_o = arm_i & s_r.seen & ~slewing_i;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end
endmodule

// File: rtl/llc_protection_deadtime_ctrl.sv
// Protection, adaptive dead time and capacitive-region handling of a half-bridge.
// Assumes phase_i comes from the waveform generator (1 = high-side half) and
// that all sense inputs are synchronous comparator levels.
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module llc_protection_deadtime_ctrl #(
  parameter int unsigned FAULT_CYC  = llc_prot_pkg::FAULT_WAIT_CYC,
  parameter int unsigned AVG_OVERCURRENT_HIGH_CYC   = llc_prot_pkg::AVG_OVERCURRENT_HIGH_WAIT_CYC,
  parameter int unsigned AVG_OVERCURRENT_LOW_CYC   = llc_prot_pkg::AVG_OVERCURRENT_LOW_WAIT_CYC,
  parameter int unsigned ZCS_DT_CYC = llc_prot_pkg::ZCS_MAX_DT_CYC,
  parameter int unsigned MAX_DT     = llc_prot_pkg::MAX_DT_CYC
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire llc_prot_pkg::wb_req_s wb_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 phase_i,
  input  wire llc_prot_pkg::sense_s sense_i,
  output logic                      high_gate_out_o,
  output logic                      low_gate_out_o,
  output logic                      light_load_soft_start_pin_oe_o,
  output logic                      bias_winding_prog_o,
  output logic                      driver_low_power_o,
  output logic                      capacitive_region_flag_o,
  output logic                      fault_o
);
  import llc_prot_pkg::*;

  localparam int FW = $clog2(FAULT_CYC + 1);
  localparam int AW2 = $clog2(AVG_OVERCURRENT_HIGH_CYC + 1);
  localparam int AW3 = $clog2(AVG_OVERCURRENT_LOW_CYC + 1);
  localparam int DW = $clog2(ZCS_DT_CYC + 1);

  typedef struct packed {
    mode_e                mode;
    logic                 enable;
    logic                 phase_q;
    logic [1:0]           gate;
    logic                 dt_act;
    logic                 dt_to_low;
    logic [DW-1:0]        dt_cnt;
    logic [DW-1:0]        dt_meas;
    logic                 capacitive_region_flag;
    logic                 pol_q;
    logic                 cyc_ovp;
    logic                 cyc_peak_overcurrent;
    logic [2:0]           ovp_cnt;
    logic [2:0]           peak_overcurrent_cnt;
    logic [3:0]           start_cnt;
    logic [AW2-1:0]       avg_overcurrent_high_cnt;
    logic [AW3-1:0]       avg_overcurrent_low_cnt;
    logic [FW-1:0]        flt_cnt;
    logic [CAUSE_W-1:0]   cause;
    logic                 ack;
    logic [31:0]          rdat;
    logic                 hi_o;
    logic                 lo_o;
    logic                 pull_o;
    logic                 prog_o;
    logic                 lp_o;
    logic                 flt_o;
  } st_s;

  st_s  s_r;
  st_s  s_nxt;
  logic slew_done;

  slew_done_det u_slew (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .arm_i     (s_r.dt_act),
    .slewing_i (sense_i.switch_node_slewing),
    .done_o    (slew_done)
  );

  function automatic logic [DW-1:0] to_dw(input int unsigned v);
    to_dw = DW'(v);
  endfunction

  always_comb begin
    logic               switching;
    logic               chg;
    logic               flip;
    logic               dt_end;
    logic [DW-1:0]      limit;
    logic [CAUSE_W-1:0] trip;
    s_nxt     = s_r;
    switching = (s_r.mode == MODE_START) || (s_r.mode == MODE_RUN);
    chg       = 1'b0;
    flip      = 1'b0;
    dt_end    = 1'b0;
    limit     = '0;
    trip      = '0;

    // Register bus: one-wait-state ack, dropped the cycle after
    s_nxt.ack = wb_i.cyc & wb_i.stb & ~s_r.ack;
    if (wb_i.cyc && wb_i.stb && !s_r.ack && wb_i.we && wb_i.sel[0] && wb_i.adr == CTRL_OFS) begin
      s_nxt.enable = wb_i.dat[CTRL_EN_BIT];
    end
    s_nxt.rdat = '0;
    unique case (wb_i.adr)
      CTRL_OFS:   s_nxt.rdat[CTRL_EN_BIT] = s_r.enable;
      STATUS_OFS: begin
        s_nxt.rdat[ST_MODE_LSB +: 2]             = s_r.mode;
        s_nxt.rdat[ST_ZCS_BIT]                   = s_r.capacitive_region_flag;
        s_nxt.rdat[ST_CAUSE_LSB +: CAUSE_W]      = s_r.cause;
      end
      DTIME_OFS:  s_nxt.rdat[DW-1:0] = s_r.dt_meas;
      default:    s_nxt.rdat = '0;
    endcase

    s_nxt.pol_q   = sense_i.current_polarity;
    s_nxt.phase_q = phase_i;

    if (switching) begin
      // Event is latched within the cycle; sense is ignored while programming
      if (s_r.mode == MODE_RUN && (sense_i.bias_winding_pos || sense_i.bias_winding_neg)) begin
        s_nxt.cyc_ovp = 1'b1;
      end
      if (s_r.gate[1] && sense_i.peak_overcurrent) begin
        s_nxt.cyc_peak_overcurrent = 1'b1;
      end
      s_nxt.avg_overcurrent_high_cnt = sense_i.avg_overcurrent_high ? s_r.avg_overcurrent_high_cnt + AW2'(1) : '0;
      s_nxt.avg_overcurrent_low_cnt = sense_i.avg_overcurrent_low ? s_r.avg_overcurrent_low_cnt + AW3'(1) : '0;
      trip[C_AVG_OVERCURRENT_HIGH] = sense_i.avg_overcurrent_high && s_r.avg_overcurrent_high_cnt == AW2'(AVG_OVERCURRENT_HIGH_CYC - 1);
      trip[C_AVG_OVERCURRENT_LOW] = sense_i.avg_overcurrent_low && s_r.avg_overcurrent_low_cnt == AW3'(AVG_OVERCURRENT_LOW_CYC - 1);

      chg = (phase_i != s_r.phase_q) && !sense_i.burst_off;
      if (chg) begin
        // Outgoing gate falls: re-evaluate the capacitive region
        s_nxt.capacitive_region_flag = (s_r.phase_q ? ~sense_i.current_polarity
                                 : sense_i.current_polarity)
                    & ~sense_i.light_load;
        s_nxt.gate      = 2'b00;
        s_nxt.dt_act    = 1'b1;
        s_nxt.dt_cnt    = '0;
        s_nxt.dt_to_low = s_r.phase_q;
        if (s_r.phase_q) begin
          // End of a switching cycle: per-cycle counters advance
          s_nxt.cyc_ovp  = 1'b0;
          s_nxt.cyc_peak_overcurrent = 1'b0;
          s_nxt.ovp_cnt  = s_r.cyc_ovp ? s_r.ovp_cnt + 3'd1 : 3'd0;
          trip[C_OVP]    = s_r.cyc_ovp && s_r.ovp_cnt == 3'(OVP_CYCLES - 1);
          if (s_r.mode == MODE_START && s_r.start_cnt < 4'(START_CYCLES)) begin
            s_nxt.peak_overcurrent_cnt  = 3'd0;
            s_nxt.start_cnt = s_r.start_cnt + 4'd1;
          end else begin
            s_nxt.peak_overcurrent_cnt = s_r.cyc_peak_overcurrent ? s_r.peak_overcurrent_cnt + 3'd1 : 3'd0;
            trip[C_PEAK_OVERCURRENT]   = s_r.cyc_peak_overcurrent && s_r.peak_overcurrent_cnt == 3'(PEAK_OVERCURRENT_CYCLES - 1);
            s_nxt.mode     = MODE_RUN;
          end
        end
      end else if (s_r.dt_act) begin
        s_nxt.dt_cnt = s_r.dt_cnt + DW'(1);
        // Edges inside the blanking window are treated as switching noise
        flip = (sense_i.current_polarity != s_r.pol_q) &&
               (s_r.dt_cnt >= to_dw(BLANK_CYC));
        if (s_r.capacitive_region_flag) begin
          limit  = to_dw(ZCS_DT_CYC);
          dt_end = flip || slew_done || (s_r.dt_cnt + DW'(1) >= limit);
        end else if (s_r.dt_to_low) begin
          limit  = to_dw(MAX_DT);
          dt_end = slew_done || (s_r.dt_cnt + DW'(1) >= limit);
          if (dt_end) begin
            s_nxt.dt_meas = s_r.dt_cnt + DW'(1);
          end
        end else begin
          // Measured value is zero only before the first measurement, which ends the copy at once, so the copy always ends
          limit  = s_r.dt_meas;
          dt_end = (s_r.dt_cnt + DW'(1) >= limit);
        end
        if (dt_end) begin
          s_nxt.dt_act = 1'b0;
          s_nxt.gate   = s_r.dt_to_low ? 2'b01 : 2'b10;
        end
      end
      if (sense_i.burst_off) begin
        s_nxt.gate   = 2'b00;
        s_nxt.dt_act = 1'b0;
      end
      trip[C_UVP]  = sense_i.bulk_below_stop;
      trip[C_REGULATED_GATE_SUPPLY] = sense_i.regulated_gate_supply_uv;
    end

    unique case (s_r.mode)
      MODE_IDLE: begin
        if (s_r.enable && !sense_i.bulk_below_stop && !sense_i.regulated_gate_supply_uv) begin
          s_nxt.mode = MODE_START;
        end
      end
      MODE_START, MODE_RUN: begin
        if (trip != '0) begin
          s_nxt.mode  = MODE_FAULT;
          s_nxt.cause = trip;
        end
      end
      MODE_FAULT: begin
        s_nxt.flt_cnt = s_r.flt_cnt + FW'(1);
        if (s_r.flt_cnt == FW'(FAULT_CYC - 1)) begin
          s_nxt.mode = MODE_START;
        end
      end
    endcase
    if (!s_nxt.enable) begin
      s_nxt.mode = MODE_IDLE;
    end

    // Leaving switching: everything that qualifies faults restarts from zero
    if (s_nxt.mode == MODE_IDLE || s_nxt.mode == MODE_FAULT || s_r.mode == MODE_FAULT) begin
      s_nxt.gate      = 2'b00;
      s_nxt.dt_act    = 1'b0;
      s_nxt.dt_cnt    = '0;
      s_nxt.capacitive_region_flag       = 1'b0;
      s_nxt.cyc_ovp   = 1'b0;
      s_nxt.cyc_peak_overcurrent  = 1'b0;
      s_nxt.ovp_cnt   = '0;
      s_nxt.peak_overcurrent_cnt  = '0;
      s_nxt.start_cnt = '0;
      s_nxt.avg_overcurrent_high_cnt  = '0;
      s_nxt.avg_overcurrent_low_cnt  = '0;
    end
    if (s_nxt.mode != MODE_FAULT) begin
      s_nxt.flt_cnt = '0;
    end

    // High side also needs its bootstrap; low side needs the gate supply
    s_nxt.hi_o   = s_nxt.gate[1] & ~sense_i.bootstrap_rail_uv
                   & ~sense_i.regulated_gate_supply_uv;
    s_nxt.lo_o   = s_nxt.gate[0] & ~sense_i.regulated_gate_supply_uv;
    s_nxt.pull_o = s_nxt.capacitive_region_flag;
    s_nxt.prog_o = s_nxt.mode == MODE_START;
    s_nxt.lp_o   = sense_i.burst_off && s_nxt.mode == MODE_RUN;
    s_nxt.flt_o  = s_nxt.mode == MODE_FAULT;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_r        <= '0;
      s_r.mode   <= MODE_IDLE;
      s_r.enable <= CTRL_EN_RST;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o                       = s_r.rdat;
  assign wb_ack_o                       = s_r.ack;
  assign high_gate_out_o                = s_r.hi_o;
  assign low_gate_out_o                 = s_r.lo_o;
  assign light_load_soft_start_pin_oe_o = s_r.pull_o;
  assign bias_winding_prog_o            = s_r.prog_o;
  assign driver_low_power_o             = s_r.lp_o;
  assign capacitive_region_flag_o       = s_r.capacitive_region_flag;
  assign fault_o                        = s_r.flt_o;
endmodule

// File: verif/llc_prot_props.sv
// Port checker for the protection and dead-time block.
// Assumes ce_i is high whenever these relations are exercised.
`timescale 1ns/1ps
module llc_prot_props (
  input wire logic                 sys_clk_i,
  input wire logic                 rst_i,
  input wire logic                 ce_i,
  input wire logic                 phase_i,
  input wire llc_prot_pkg::sense_s sense_i,
  input wire logic                 high_gate_out_o,
  input wire logic                 low_gate_out_o,
  input wire logic                 light_load_soft_start_pin_oe_o,
  input wire logic                 driver_low_power_o,
  input wire logic                 capacitive_region_flag_o,
  input wire logic                 fault_o
);
  import llc_prot_pkg::*;
  localparam int DT_LIM = 256;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence high_to_low;
    $fell(phase_i) && high_gate_out_o && ce_i && !sense_i.burst_off && !capacitive_region_flag_o;
  endsequence
  // Phase may return first; a restarted dead time is not a late turn-on
  sequence low_turn_on;
    ##[1:DT_LIM] (low_gate_out_o || fault_o || phase_i);
  endsequence
  AST_DEAD_MAX: assert property (high_to_low |-> low_turn_on)
    else $error("low gate late after dead time");
  AST_NO_OVERLAP: assert property (!(high_gate_out_o && low_gate_out_o))
    else $error("both gates on");
  AST_FAULT_OFF: assert property (fault_o && $past(fault_o) |-> !high_gate_out_o && !low_gate_out_o)
    else $error("gate on in fault");
  AST_SS_PIN: assert property (light_load_soft_start_pin_oe_o == capacitive_region_flag_o)
    else $error("soft-start pull differs from flag");
  AST_FLAG_SRC: assert property ($rose(capacitive_region_flag_o) |-> $past(phase_i) != $past(phase_i, 2))
    else $error("flag set without gate fall");
  AST_BULK: assert property (sense_i.bulk_below_stop && ce_i |-> ##[1:3] fault_o)
    else $error("bulk drop without fault");
  AST_REGULATED_GATE_SUPPLY: assert property (sense_i.regulated_gate_supply_uv && ce_i |=> !high_gate_out_o && !low_gate_out_o)
    else $error("gate on at supply uv");
  AST_BOOT: assert property (sense_i.bootstrap_rail_uv && ce_i |=> !high_gate_out_o)
    else $error("high gate on at boot uv");
  AST_BURST: assert property (sense_i.burst_off && ce_i |=> !high_gate_out_o && !low_gate_out_o)
    else $error("gate on in burst off");
endmodule

bind llc_protection_deadtime_ctrl llc_prot_props props_u (.sys_clk_i, .rst_i, .ce_i, .phase_i,
  .sense_i, .high_gate_out_o, .low_gate_out_o, .light_load_soft_start_pin_oe_o,
  .driver_low_power_o, .capacitive_region_flag_o, .fault_o);

// File: verif/tank_model.sv
// Tank stand-in: switch-node slew comparator and current polarity.
// Assumes gate commands are registered on the same clock.
`timescale 1ns/1ps
module tank_model (
  input  wire logic       sys_clk_i,
  input  wire logic       high_gate_i,
  input  wire logic       low_gate_i,
  input  wire logic [1:0] slew_mode_i,
  input  wire logic       cap_i,
  output logic            slewing_o,
  output logic            polarity_o
);
  int   cnt  = 0;
  logic hi_q = 1'b0;
  logic lo_q = 1'b0;
  // Inductive current follows the high gate; cap_i reverses it
  assign polarity_o = high_gate_i ^ cap_i;
  initial slewing_o = 1'b0;
  // Mode 0 never slews, 1 rises then falls, 2 rises and sticks
  always @(posedge sys_clk_i) begin
    hi_q <= high_gate_i;
    lo_q <= low_gate_i;
    cnt  <= ((hi_q && !high_gate_i) || (lo_q && !low_gate_i)) ? 1 : cnt + 1;
    if (high_gate_i || low_gate_i) slewing_o <= 1'b0;
    else if (slew_mode_i != 2'h0 && cnt == 20) slewing_o <= 1'b1;
    else if (slew_mode_i == 2'h1 && cnt == 40) slewing_o <= 1'b0;
  end
endmodule

// File: verif/llc_protection_deadtime_ctrl_tb.sv
// Bench: bus tasks, dead-time probes and a fault table.
// Assumes the tank model answers the gates on the far side.
`timescale 1ns/1ps
module llc_protection_deadtime_ctrl_tb;
  import llc_prot_pkg::*;
  localparam int HALF = 300;
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        ce        = 1'b1;
  logic        phase_i   = 1'b0;
  logic [1:0]  slew_mode = 2'h1;
  logic        cap       = 1'b0;
  wb_req_s     wb_r      = '0;
  sense_s      sense_r   = '0;
  sense_s      sense_w;
  logic [31:0] rd, wb_dat_o;
  logic        wb_ack_o, hi_g, lo_g, ss_oe, prog, lowp, flag, fault, slew, pol;
  int          fails = 0, checked = 0, cnt = 0, dl = 0, dh = 0;
  // Cols: sense bit, settle, quiet, span, cause bit
  int          tab [7][5] = '{'{8, 0, 40, 30, 2}, '{7, 0, 110, 30, 3}, '{6, 0, 0, 4, 4},
    '{5, 0, 0, 4, 5}, '{9, 0, 8400, 4800, 1}, '{11, 9600, 2700, 500, 0}, '{10, 9600, 2700, 500, 0}};

  initial forever #2 sys_clk_i = ~sys_clk_i;
  always_comb begin
    sense_w = sense_r;
    sense_w.switch_node_slewing = slew;
    sense_w.current_polarity = pol;
  end
  // Free-running half-bridge phase; dead time measured from each change
  always @(posedge sys_clk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) phase_i <= ~phase_i;
    if ($rose(lo_g)) dl <= cnt;
    if ($rose(hi_g)) dh <= cnt;
  end

  llc_protection_deadtime_ctrl #(.FAULT_CYC(200), .AVG_OVERCURRENT_HIGH_CYC(50), .AVG_OVERCURRENT_LOW_CYC(120),
    .ZCS_DT_CYC(400), .MAX_DT(250)) dut_u (.sys_clk_i, .rst_i, .ce_i(ce), .wb_i(wb_r),
    .wb_dat_o, .wb_ack_o, .phase_i, .sense_i(sense_w), .high_gate_out_o(hi_g),
    .low_gate_out_o(lo_g), .light_load_soft_start_pin_oe_o(ss_oe), .bias_winding_prog_o(prog),
    .driver_low_power_o(lowp), .capacitive_region_flag_o(flag), .fault_o(fault));
  tank_model tank_u (.sys_clk_i, .high_gate_i(hi_g), .low_gate_i(lo_g), .slew_mode_i(slew_mode),
    .cap_i(cap), .slewing_o(slew), .polarity_o(pol));

  task automatic clk(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge sys_clk_i);
    wb_r <= '{1'b1, 1'b1, we, 4'hF, adr, dat};
    do begin
      @(posedge sys_clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_r <= '0;
    @(posedge sys_clk_i);
  endtask
  task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_b(input logic got, input logic exp);
    cmp_w({31'h0, got}, {31'h0, exp});
  endtask
  task automatic stop_test();
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    stop_test();
  end
  initial begin
    clk(10);
    rst_i <= 1'b0;
    wb(1'b0, CTRL_OFS, 32'h0);
    cmp_w(rd, 32'h0);
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h0C, 32'h0);
    cmp_w(rd, 32'h0);
    wb(1'b1, CTRL_OFS, 32'h1);
    wb(1'b0, STATUS_OFS, 32'h0);
    cmp_w(rd & 32'h7, 32'h1);
    cmp_b(prog, 1'b1);
    clk(9600);
    wb(1'b0, STATUS_OFS, 32'h0);
    cmp_w(rd & 32'h7, 32'h2);
    cmp_b(prog, 1'b0);
    cmp_b(dl < 250, 1'b1);
    cmp_w(dh, dl);
    for (int m = 0; m < 3; m += 2) begin
      slew_mode <= 2'(m);
      clk(1300);
      cmp_b(dl >= 249 && dl <= 253, 1'b1);
      cmp_w(dh, dl);
    end
    wb(1'b0, DTIME_OFS, 32'h0);
    cmp_w(rd, 32'h0000_00FA);
    slew_mode <= 2'h1;
    cap <= 1'b1;
    clk(1300);
    cmp_b(flag, 1'b1);
    cmp_b(ss_oe, 1'b1);
    cmp_b(dl < 250, 1'b1);
    cmp_b(dl > 20, 1'b1);
    wb(1'b0, STATUS_OFS, 32'h0);
    cmp_w(rd & 32'h4, 32'h4);
    sense_r.light_load <= 1'b1;
    clk(1300);
    cmp_b(flag, 1'b0);
    cap <= 1'b0;
    sense_r.light_load <= 1'b0;
    sense_r.burst_off <= 1'b1;
    clk(10);
    cmp_b(lowp, 1'b1);
    sense_r.burst_off <= 1'b0;
    sense_r.bootstrap_rail_uv <= 1'b1;
    clk(700);
    cmp_b(fault, 1'b0);
    sense_r.bootstrap_rail_uv <= 1'b0;
    // Freeze while the low gate is on: the phase change must not be seen
    @(posedge phase_i);
    ce <= 1'b0;
    clk(50);
    cmp_b(lo_g, 1'b1);
    cmp_b(hi_g, 1'b0);
    ce <= 1'b1;
    foreach (tab[i]) begin
      clk(tab[i][1]);
      @(negedge phase_i);
      @(posedge sys_clk_i);
      sense_r[tab[i][0]] <= 1'b1;
      clk(tab[i][2]);
      cmp_b(fault, 1'b0);
      for (int n = 0; n < tab[i][3] && fault !== 1'b1; n++) clk(1);
      sense_r[tab[i][0]] <= 1'b0;
      cmp_b(fault, 1'b1);
      wb(1'b0, STATUS_OFS, 32'h0);
      cmp_w(rd & 32'h3F03, (32'h1 << (8 + tab[i][4])) | 32'h3);
      clk(180);
      cmp_b(fault, 1'b1);
      clk(30);
      wb(1'b0, STATUS_OFS, 32'h0);
      cmp_w(rd & 32'h3, 32'h1);
    end
    wb(1'b1, CTRL_OFS, 32'h0);
    wb(1'b0, STATUS_OFS, 32'h0);
    cmp_w(rd & 32'h3, 32'h0);
    stop_test();
  end
endmodule
